// [design/fmf_pkg.sv]
// Purpose: Constants and types for the fan tach monitor and fault block
// Assumes: 25 MHz system clock, byte-wide internal register port
// Notes: Register offsets besides 0x01, 0x02 and 0x20 are local choices
package fmf_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_CFG_ONE = 8'h00;
  localparam logic [7:0] ADDR_CFG_TWO = 8'h01;
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h02;
  localparam logic [7:0] ADDR_CFG_FOUR = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI = 8'h09;
  localparam logic [7:0] ADDR_LOLIM_LO = 8'h0a;
  localparam logic [7:0] ADDR_LOLIM_HI = 8'h0b;
  localparam logic [7:0] ADDR_HILIM_LO = 8'h0c;
  localparam logic [7:0] ADDR_HILIM_HI = 8'h0d;
  localparam logic [7:0] ADDR_FAN_CHAR = 8'h20;
  localparam logic [7:0] ADDR_DUTY = 8'h22;

  // Field positions
  localparam int CFG1_START_BIT = 0;
  localparam int CFG1_FAN_RANGE_IRQ_ENABLE_BIT = 2;
  localparam int CFG1_MODE_LSB = 3;
  localparam int CFG1_FAULT_EN_BIT = 5;
  localparam int CFG2_TACH_MODE_BIT = 1;
  localparam int CFG2_TACH_EN_BIT = 2;
  localparam int CFG4_PULSES_PER_REV_SELECT_BIT = 3;
  localparam int CFG4_FAST_BIT = 5;
  localparam int STAT1_OVERSPEED_BIT = 0;
  localparam int STAT1_FANS_BIT = 1;
  localparam int FCHAR_SPIN_DIS_BIT = 5;

  // Reset values
  localparam logic [7:0] CFG_ONE_RST = 8'h00;
  localparam logic [7:0] CFG_TWO_RST = 8'h00;
  localparam logic [7:0] CFG_FOUR_RST = 8'h00;
  localparam logic [7:0] FAN_CHAR_RST = 8'h05;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [15:0] LOLIM_RST = 16'hffff;
  localparam logic [15:0] HILIM_RST = 16'h0000;

  // Duty thresholds, 1 LSB = 1/255
  localparam logic [7:0] DUTY_7PCT = 8'h12;
  localparam logic [7:0] DUTY_30PCT = 8'h4d;
  localparam logic [7:0] DUTY_SPIN_LO = 8'h55;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] DUTY_ZERO = 8'h00;

  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_HZ = 100_000;
  localparam int TICK_CYC = CLK_HZ / TICK_HZ;
  localparam int MON_SLOW_MS = 1000;
  localparam int MON_FAST_MS = 250;
  localparam int SPIN_UNIT_MS = 200;
  localparam int SPIN_RAMP_STEPS = 170;
  localparam logic [2:0] SPIN_TRIES_MAX = 3'd5;

  typedef enum logic [1:0] {
    MODE_SW_DUTY = 2'b00,
    MODE_SW_SPEED = 2'b01,
    MODE_AUTO_REMOTE = 2'b10,
    MODE_AUTO_MAX = 2'b11
  } fmf_mode_t;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_WAIT = 2'b01,
    MS_COUNT = 2'b10
  } fmf_meas_t;

  // Spin-up length in 0.2 s units
  function automatic logic [7:0] fmf_spin_units(input logic [2:0] sel);
    case (sel)
      3'd0: fmf_spin_units = 8'd1;
      3'd1: fmf_spin_units = 8'd2;
      3'd2: fmf_spin_units = 8'd3;
      3'd3: fmf_spin_units = 8'd4;
      3'd4: fmf_spin_units = 8'd5;
      3'd5: fmf_spin_units = 8'd10;
      3'd6: fmf_spin_units = 8'd20;
      default: fmf_spin_units = 8'd40;
    endcase
  endfunction

endpackage

// [design/fmf_fan_monitor.sv]
// Purpose: Fan period measurement, speed limits, spin-up and fault pin
// Assumes: Register port is driven by the serial slave on the same clock
// Notes: Tach pin is synchronised; long timers are module parameters
`timescale 1ns/100ps

module fmf_fan_monitor
  import fmf_pkg::*;
#(
  parameter int MON_SLOW_CYC = CLK_HZ / 1000 * MON_SLOW_MS,
  parameter int MON_FAST_CYC = CLK_HZ / 1000 * MON_FAST_MS,
  parameter int SPIN_UNIT_CYC = CLK_HZ / 1000 * SPIN_UNIT_MS
) (
  input wire logic i_sys_clk, // System clock
  input wire logic i_reset, // Async reset, active high
  input wire logic i_tach, // Tach pin from fan
  input wire logic i_reg_wr, // Register write strobe
  input wire logic i_reg_rd, // Register read strobe
  input wire logic [7:0] i_reg_addr, // Register offset
  input wire logic [7:0] i_reg_wdata, // Write data
  output logic [7:0] o_reg_rdata, // Read data, held
  output logic [7:0] o_duty_out, // Duty to PWM generator
  output logic o_pwm_force_on, // Hold PWM on
  output logic o_correct_en, // Duty correction enable
  output logic [1:0] o_mode, // Control mode selection
  output logic o_spinup_active, // Spin-up running
  output logic o_fan_range_event, // Fan out-of-range event
  output logic o_smbalert_n, // Alert, active low
  output logic o_fault_o, // Fault pin output level
  output logic o_fault_oe // Fault pin drive enable
);

  localparam int SPIN_STEP_CYC = SPIN_UNIT_CYC / (3 * SPIN_RAMP_STEPS);

  // Registers
  logic [7:0] cfg_one_q;
  logic [7:0] config_two_q;
  logic [7:0] cfg_four_q;
  logic [7:0] fan_char_q;
  logic [7:0] duty_cycle_reg_q;
  logic [15:0] lolim_q;
  logic [15:0] hilim_q;
  logic [15:0] fan_period_count_q;
  logic [7:0] hi_hold_q;
  logic frozen_q;

  // Control fields
  wire start_bit = cfg_one_q[CFG1_START_BIT];
  wire fan_range_irq_enable = cfg_one_q[CFG1_FAN_RANGE_IRQ_ENABLE_BIT];
  wire fault_en = cfg_one_q[CFG1_FAULT_EN_BIT];
  wire [1:0] mode = cfg_one_q[CFG1_MODE_LSB +: 2];
  wire tach_en = config_two_q[CFG2_TACH_EN_BIT];
  wire tach_mode = config_two_q[CFG2_TACH_MODE_BIT];
  wire pulses_per_rev_select = cfg_four_q[CFG4_PULSES_PER_REV_SELECT_BIT];
  wire fast_rate = cfg_four_q[CFG4_FAST_BIT];
  wire spinup_disable = fan_char_q[FCHAR_SPIN_DIS_BIT];
  wire [2:0] spinup_time_sel = fan_char_q[2:0];
  wire speed_mode = (mode == MODE_SW_SPEED);

  // Tach synchroniser and filtered level
  logic [2:0] tach_sync_q;
  logic tach_lvl_q;
  wire tach_agree = (tach_sync_q[1] == tach_sync_q[2]);
  wire tach_rise = tach_agree & tach_sync_q[2] & ~tach_lvl_q;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      tach_sync_q <= 3'b111;
      tach_lvl_q <= 1'b1;
    end else begin
      tach_sync_q <= {tach_sync_q[1:0], i_tach};
      if (tach_agree) begin
        tach_lvl_q <= tach_sync_q[2];
      end
    end
  end

  // 100 kHz tick
  logic [7:0] tick_cnt_q;
  wire tick = (tick_cnt_q == 8'(TICK_CYC - 1));

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      tick_cnt_q <= 8'h00;
    end else begin
      tick_cnt_q <= tick ? 8'h00 : tick_cnt_q + 8'h01;
    end
  end

  // Monitoring permission
  wire low_duty = (duty_cycle_reg_q < DUTY_7PCT);
  wire mon_run = start_bit & tach_en
    & (tach_mode | speed_mode | ~low_duty);

  // Monitoring period timer
  logic [31:0] mon_tmr_q;
  wire [31:0] mon_limit = fast_rate ? 32'(MON_FAST_CYC)
                                    : 32'(MON_SLOW_CYC);
  wire mon_due = mon_run & (mon_tmr_q >= mon_limit - 32'd1);

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      mon_tmr_q <= 32'd0;
    end else begin
      mon_tmr_q <= (~mon_run | mon_due) ? 32'd0 : mon_tmr_q + 32'd1;
    end
  end

  // Period measurement
  fmf_meas_t meas_q;
  fmf_meas_t meas_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [2:0] edges_q;
  logic [2:0] edges_d;
  logic spinning_q;
  logic spin_end;

  wire cnt_sat = (cnt_q == 16'hffff);
  wire [2:0] edges_need = pulses_per_rev_select ? 3'd4 : 3'd2;
  wire meas_done = mon_run & (((meas_q == MS_WAIT) & cnt_sat)
    | ((meas_q == MS_COUNT)
    & (cnt_sat | (tach_rise & (edges_q == edges_need - 3'd1)))));
  wire start_meas = mon_run & (meas_q == MS_IDLE)
    & ((mon_due & ~spinning_q) | spin_end);
  wire fan_slow = (cnt_q > lolim_q);
  wire fan_fast = (cnt_q < hilim_q);

  always_comb begin
    meas_d = meas_q;
    cnt_d = cnt_q;
    edges_d = edges_q;
    case (meas_q)
      MS_IDLE: begin
        if (start_meas) begin
          meas_d = MS_WAIT;
          cnt_d = 16'h0000;
          edges_d = 3'd0;
        end
      end
      MS_WAIT: begin
        if (tach_rise) begin
          meas_d = MS_COUNT;
          cnt_d = 16'h0000;
        end else if (tick & ~cnt_sat) begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      MS_COUNT: begin
        if (tach_rise) begin
          edges_d = edges_q + 3'd1;
        end
        if (tick & ~cnt_sat) begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      default: meas_d = MS_IDLE;
    endcase
    if (meas_done | ~mon_run) begin
      meas_d = MS_IDLE;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      meas_q <= MS_IDLE;
      cnt_q <= 16'h0000;
      edges_q <= 3'd0;
      fan_period_count_q <= 16'h0000;
    end else begin
      meas_q <= meas_d;
      cnt_q <= cnt_d;
      edges_q <= edges_d;
      if (meas_done) begin
        fan_period_count_q <= cnt_q;
      end
    end
  end

  // Spin-up sequencing
  logic [31:0] spin_cnt_q;
  logic [31:0] step_cnt_q;
  logic [7:0] spin_duty_q;
  logic settle_q;
  logic [2:0] tries_q;
  logic fail_q;

  wire [7:0] spin_units = fmf_spin_units(spinup_time_sel);
  wire [31:0] spin_len = 32'(spin_units) * 32'(SPIN_UNIT_CYC);
  wire [31:0] step_len = 32'(spin_units) * 32'(SPIN_STEP_CYC);
  wire step_hit = (step_cnt_q >= step_len - 32'd1);
  assign spin_end = spinning_q & (spin_cnt_q >= spin_len - 32'd1);
  wire spin_start = meas_done & fan_slow & ~spinup_disable
    & ~spinning_q;

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      spinning_q <= 1'b0;
      spin_cnt_q <= 32'd0;
      step_cnt_q <= 32'd0;
      spin_duty_q <= DUTY_SPIN_LO;
    end else if (spin_start) begin
      spinning_q <= 1'b1;
      spin_cnt_q <= 32'd0;
      step_cnt_q <= 32'd0;
      spin_duty_q <= DUTY_SPIN_LO;
    end else if (spinning_q) begin
      spinning_q <= ~spin_end;
      spin_cnt_q <= spin_cnt_q + 32'd1;
      step_cnt_q <= step_hit ? 32'd0 : step_cnt_q + 32'd1;
      if (step_hit & (spin_duty_q != DUTY_FULL)) begin
        spin_duty_q <= spin_duty_q + 8'h01;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      settle_q <= 1'b0;
      tries_q <= 3'd0;
      fail_q <= 1'b0;
    end else begin
      if (spin_end) begin
        settle_q <= 1'b1;
      end else if (meas_done | ~mon_run) begin
        settle_q <= 1'b0;
      end
      if (meas_done & ~fan_slow) begin
        tries_q <= 3'd0;
        fail_q <= 1'b0;
      end else if (meas_done & fan_slow) begin
        if (tries_q == SPIN_TRIES_MAX) begin
          fail_q <= 1'b1;
        end
        if (spin_start & (tries_q != SPIN_TRIES_MAX)) begin
          tries_q <= tries_q + 3'd1;
        end
      end
    end
  end

  // Status flags; a set in the clearing cycle wins
  logic fans_q;
  logic over_q;
  logic over_arm_q;
  logic alert_q;
  wire stat_rd = i_reg_rd & (i_reg_addr == ADDR_STATUS_ONE);
  wire fans_set = (meas_done & fan_slow & ~spinning_q)
    | spin_end;
  wire fans_d = fans_set | (fans_q & ~stat_rd);
  wire over_set = meas_done & fan_fast & over_arm_q;
  wire over_d = over_set | (over_q & ~stat_rd);

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      fans_q <= 1'b0;
      over_q <= 1'b0;
      over_arm_q <= 1'b1;
      alert_q <= 1'b0;
    end else begin
      fans_q <= fans_d;
      over_q <= over_d;
      if (meas_done & ~fan_fast) begin
        over_arm_q <= 1'b1;
      end else if (stat_rd & over_q) begin
        over_arm_q <= 1'b0;
      end
      alert_q <= fan_range_irq_enable & (fans_d | over_d);
    end
  end

  // Duty adjustment toward the PWM generator
  logic [7:0] duty_adj;
  always_comb begin
    duty_adj = duty_cycle_reg_q;
    if (~tach_mode) begin
      if (speed_mode & (duty_cycle_reg_q < DUTY_30PCT)) begin
        duty_adj = DUTY_30PCT;
      end else if (~speed_mode & low_duty) begin
        duty_adj = DUTY_ZERO;
      end
    end
  end

  wire [7:0] duty_d = spinning_q ? spin_duty_q
                    : (settle_q ? DUTY_SPIN_LO : duty_adj);
  wire force_d = ~tach_mode & (meas_q != MS_IDLE);

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_duty_out <= DUTY_ZERO;
      o_pwm_force_on <= 1'b0;
    end else begin
      o_duty_out <= duty_d;
      o_pwm_force_on <= force_d;
    end
  end

  // Register write and read
  wire [7:0] status_one = {6'h00, fans_q, over_q};
  logic [7:0] rd_mux;
  always_comb begin
    case (i_reg_addr)
      ADDR_CFG_ONE: rd_mux = cfg_one_q;
      ADDR_CFG_TWO: rd_mux = config_two_q;
      ADDR_STATUS_ONE: rd_mux = status_one;
      ADDR_CFG_FOUR: rd_mux = cfg_four_q;
      ADDR_CNT_LO: rd_mux = fan_period_count_q[7:0];
      ADDR_CNT_HI: rd_mux = frozen_q ? hi_hold_q
                                     : fan_period_count_q[15:8];
      ADDR_LOLIM_LO: rd_mux = lolim_q[7:0];
      ADDR_LOLIM_HI: rd_mux = lolim_q[15:8];
      ADDR_HILIM_LO: rd_mux = hilim_q[7:0];
      ADDR_HILIM_HI: rd_mux = hilim_q[15:8];
      ADDR_FAN_CHAR: rd_mux = fan_char_q;
      ADDR_DUTY: rd_mux = duty_cycle_reg_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_reg_rdata <= 8'h00;
      hi_hold_q <= 8'h00;
      frozen_q <= 1'b0;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_mux;
      if (i_reg_addr == ADDR_CNT_LO) begin
        hi_hold_q <= fan_period_count_q[15:8];
        frozen_q <= 1'b1;
      end else if (i_reg_addr == ADDR_CNT_HI) begin
        frozen_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg_one_q <= CFG_ONE_RST;
      config_two_q <= CFG_TWO_RST;
      cfg_four_q <= CFG_FOUR_RST;
      fan_char_q <= FAN_CHAR_RST;
      duty_cycle_reg_q <= DUTY_RST;
      lolim_q <= LOLIM_RST;
      hilim_q <= HILIM_RST;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_CFG_ONE: cfg_one_q <= i_reg_wdata;
        ADDR_CFG_TWO: config_two_q <= i_reg_wdata;
        ADDR_CFG_FOUR: cfg_four_q <= i_reg_wdata;
        ADDR_FAN_CHAR: fan_char_q <= i_reg_wdata;
        ADDR_DUTY: duty_cycle_reg_q <= i_reg_wdata;
        ADDR_LOLIM_LO: lolim_q[7:0] <= i_reg_wdata;
        ADDR_LOLIM_HI: lolim_q[15:8] <= i_reg_wdata;
        ADDR_HILIM_LO: hilim_q[7:0] <= i_reg_wdata;
        ADDR_HILIM_HI: hilim_q[15:8] <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // Outputs
  assign o_correct_en = ~tach_mode;
  assign o_mode = mode;
  assign o_spinup_active = spinning_q;
  assign o_fan_range_event = alert_q;
  assign o_smbalert_n = ~alert_q;
  assign o_fault_o = 1'b0;
  assign o_fault_oe = fault_en & fail_q;

endmodule

// [test/fmf_fan_monitor_asserts.sv]
// Purpose: Port assertions for the fan tach monitor
// Assumes: One clock domain, async active-high reset
// Notes: Bound into every instance of the monitor
`timescale 1ns/100ps
module fmf_fan_monitor_asserts
  import fmf_pkg::*;
(
  input wire logic i_sys_clk, // Clock
  input wire logic i_reset, // Reset
  input wire logic i_reg_rd, // Read strobe
  input wire logic [7:0] o_reg_rdata, // Read data
  input wire logic [7:0] o_duty_out, // Duty out
  input wire logic o_pwm_force_on, // Force on
  input wire logic o_correct_en, // Correction
  input wire logic [1:0] o_mode, // Mode
  input wire logic o_spinup_active, // Spin-up
  input wire logic o_fan_range_event, // Range event
  input wire logic o_smbalert_n, // Alert
  input wire logic o_fault_o, // Fault level
  input wire logic o_fault_oe // Fault enable
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  property p_alert;
    o_smbalert_n == !o_fan_range_event;
  endproperty
  a_alert: assert property (p_alert) else $error("alert mismatch");
  property p_fault_low;
    o_fault_oe |-> o_fault_o == 1'b0;
  endproperty
  a_fault_low: assert property (p_fault_low) else $error("fault high");
  property p_no_force;
    !o_correct_en && $past(!o_correct_en) |-> !o_pwm_force_on;
  endproperty
  a_no_force: assert property (p_no_force) else $error("forced");
  property p_floor;
    o_correct_en && $past(o_correct_en) && o_mode == MODE_SW_SPEED &&
      $past(o_mode) == MODE_SW_SPEED |-> o_duty_out >= DUTY_30PCT;
  endproperty
  a_floor: assert property (p_floor) else $error("duty under floor");
  property p_zero;
    o_correct_en && $past(o_correct_en) && o_mode != MODE_SW_SPEED &&
      $past(o_mode) != MODE_SW_SPEED
      |-> o_duty_out == DUTY_ZERO || o_duty_out >= DUTY_7PCT;
  endproperty
  a_zero: assert property (p_zero) else $error("low duty passed");
  property p_spin_open;
    $rose(o_spinup_active) |-> ##[0:2] o_duty_out == DUTY_SPIN_LO;
  endproperty
  a_spin_open: assert property (p_spin_open) else $error("ramp start");
  property p_spin_end;
    $fell(o_spinup_active) |-> $past(o_duty_out) == DUTY_FULL
      ##[0:1] o_duty_out == DUTY_SPIN_LO;
  endproperty
  a_spin_end: assert property (p_spin_end) else $error("spin end");
  property p_rdata_hold;
    !i_reg_rd |=> $stable(o_reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata");
  property p_no_meas_spin;
    o_spinup_active && $past(o_spinup_active) |-> !o_pwm_force_on;
  endproperty
  a_no_meas_spin: assert property (p_no_meas_spin) else $error("meas");

  c_spin: cover property ($rose(o_spinup_active));
  c_fault: cover property ($rose(o_fault_oe));
  c_event: cover property ($rose(o_fan_range_event));
  c_force: cover property ($rose(o_pwm_force_on));
endmodule

bind fmf_fan_monitor fmf_fan_monitor_asserts u_fmf_fan_monitor_asserts (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_duty_out(o_duty_out),
  .o_pwm_force_on(o_pwm_force_on), .o_correct_en(o_correct_en),
  .o_mode(o_mode), .o_spinup_active(o_spinup_active),
  .o_fan_range_event(o_fan_range_event), .o_smbalert_n(o_smbalert_n),
  .o_fault_o(o_fault_o), .o_fault_oe(o_fault_oe)
);

// [test/fmf_fan_model.sv]
// Purpose: Fan tach output model
// Assumes: Tach is open collector with a pull-up
// Notes: Unpowered or zero half period leaves the pin pulled high
`timescale 1ns/100ps
module fmf_fan_model (
  input wire logic i_clk, // Bench clock
  input wire logic i_pwr, // Fan has power
  input var int i_half, // Half period in clocks
  output logic o_tach // Tach pin level
);
  int cnt_q = 0;
  initial o_tach = 1'b1;
  always @(posedge i_clk) begin
    if (!i_pwr || i_half == 0) begin
      cnt_q <= 0;
      o_tach <= 1'b1;
    end else if (cnt_q >= i_half - 1) begin
      cnt_q <= 0;
      o_tach <= ~o_tach;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule

// [test/fan_tach_monitor_fault_tb.sv]
// Purpose: Self-checking bench for the fan tach monitor
// Assumes: Shortened monitor and spin-up timers
// Notes: Counts are 100 kHz ticks, 250 clocks each, one tick tolerance
`timescale 1ns/100ps
module fan_tach_monitor_fault_tb
  import fmf_pkg::*;
;
  localparam int MS = 3000;
  localparam int MF = 1500;
  localparam int WM = 2 * MS;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] rdata, duty, d;
  logic [15:0] c;
  logic [1:0] mode;
  logic force_on, corr, spin, evt, alert_n, flt_o, flt_oe, tach;
  int half = 250;
  int n_fail = 0;
  int checks_done = 0;
  int n_spin = 0;
  int gap = 0;
  time t_rise = 0;
  wire logic fan_pwr = !corr || force_on || (duty != 8'h00);
  wire logic fault_pin = flt_oe ? flt_o : 1'b1;

  fmf_fan_monitor #(.MON_SLOW_CYC(MS), .MON_FAST_CYC(MF),
    .SPIN_UNIT_CYC(1020)) u_fmf_fan_monitor (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_tach(tach),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(rdata), .o_duty_out(duty),
    .o_pwm_force_on(force_on), .o_correct_en(corr), .o_mode(mode),
    .o_spinup_active(spin), .o_fan_range_event(evt),
    .o_smbalert_n(alert_n), .o_fault_o(flt_o), .o_fault_oe(flt_oe));
  fmf_fan_model u_fmf_fan_model (.i_clk(i_sys_clk), .i_pwr(fan_pwr),
    .i_half(half), .o_tach(tach));

  initial begin
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge force_on) begin
    gap = int'(($time - t_rise) / 40);
    t_rise = $time;
  end
  always @(posedge spin) n_spin++;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
    checks_done++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, lo[15:0]);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_sys_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = v;
    @(negedge i_sys_clk);
    i_reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge i_sys_clk);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_sys_clk);
    i_reg_rd = 1'b0;
    v = rdata;
  endtask
  task automatic rd_cnt(output logic [15:0] v);
    logic [7:0] l, h;
    rd(ADDR_CNT_LO, l);
    rd(ADDR_CNT_HI, h);
    v = {h, l};
  endtask

  task automatic t_reset;
    rd(ADDR_CFG_TWO, d);
    chk(d, 8'h00);
    rd(ADDR_CFG_FOUR, d);
    chk(d, 8'h00);
    rd(ADDR_FAN_CHAR, d);
    chk(d, 8'h05);
    rd(ADDR_LOLIM_HI, d);
    chk(d, 8'hff);
    rd(8'h3f, d);
    chk(d, 8'h00);
    rd_cnt(c);
    chk(c, 16'h0000);
    chk(fault_pin, 1'b1);
    chk(alert_n, 1'b1);
  endtask
  task automatic t_enable;
    wr(ADDR_CFG_TWO, 8'h06);
    wt(MS);
    rd_cnt(c);
    chk(c, 16'h0000);
    wr(ADDR_CFG_ONE, 8'h01);
    wr(ADDR_CFG_TWO, 8'h02);
    wt(MS);
    rd_cnt(c);
    chk(c, 16'h0000);
    wr(ADDR_CFG_TWO, 8'h06);
    wt(WM);
    rd_cnt(c);
    chk_rng(c, 3, 5);
    chk(force_on, 1'b0);
    chk(corr, 1'b0);
    wr(ADDR_CFG_FOUR, 8'h08);
    wt(WM);
    rd_cnt(c);
    chk_rng(c, 7, 9);
    wr(ADDR_CFG_FOUR, 8'h00);
  endtask
  task automatic t_mode0;
    logic [15:0] c0;
    wr(ADDR_DUTY, 8'h10);
    wr(ADDR_CFG_TWO, 8'h04);
    wt(MS);
    chk(duty, DUTY_ZERO);
    rd_cnt(c0);
    half = 375;
    wt(WM);
    rd_cnt(c);
    chk(c, c0);
    wr(ADDR_CFG_ONE, 8'h09);
    wt(4);
    chk(mode, MODE_SW_SPEED);
    chk(duty, DUTY_30PCT);
    wt(WM + 100);
    rd_cnt(c);
    chk_rng(c, 5, 7);
    chk_rng(gap, MS - 2, MS + 2);
    half = 200;
    wr(ADDR_CFG_FOUR, 8'h20);
    wt(MS + 2 * MF);
    chk_rng(gap, MF - 2, MF + 2);
    wr(ADDR_CFG_FOUR, 8'h00);
    wr(ADDR_CFG_TWO, 8'h06);
    wr(ADDR_CFG_ONE, 8'h01);
    half = 250;
  endtask
  task automatic t_over;
    wr(ADDR_CFG_ONE, 8'h05);
    wr(ADDR_HILIM_LO, 8'h10);
    for (int i = 0; i < WM && alert_n !== 1'b0; i++) wt(1);
    chk(evt, 1'b1);
    rd(ADDR_STATUS_ONE, d);
    chk(d[STAT1_OVERSPEED_BIT], 1'b1);
    wt(2);
    chk(alert_n, 1'b1);
    wt(WM);
    rd(ADDR_STATUS_ONE, d);
    chk(d[STAT1_OVERSPEED_BIT], 1'b0);
    wr(ADDR_HILIM_LO, 8'h00);
    wt(WM);
    wr(ADDR_HILIM_LO, 8'h10);
    wt(WM);
    rd(ADDR_STATUS_ONE, d);
    chk(d[STAT1_OVERSPEED_BIT], 1'b1);
    wr(ADDR_HILIM_LO, 8'h00);
    rd(ADDR_STATUS_ONE, d);
  endtask
  task automatic t_nospin;
    wr(ADDR_FAN_CHAR, 8'h20);
    wr(ADDR_LOLIM_HI, 8'h00);
    wr(ADDR_LOLIM_LO, 8'h01);
    n_spin = 0;
    wt(WM);
    chk(n_spin[15:0], 16'h0000);
    chk(alert_n, 1'b0);
    rd(ADDR_STATUS_ONE, d);
    chk(d[STAT1_FANS_BIT], 1'b1);
  endtask
  task automatic t_fail;
    wr(ADDR_CFG_ONE, 8'h21);
    n_spin = 0;
    wr(ADDR_FAN_CHAR, 8'h00);
    for (int i = 0; i < 30000 && flt_oe !== 1'b1; i++) wt(1);
    chk(n_spin[15:0], 16'h0006);
    chk(fault_pin, 1'b0);
    for (int i = 0; i < 4000 && spin !== 1'b1; i++) wt(1);
    chk(spin, 1'b1);
    rd(ADDR_STATUS_ONE, d);
    wr(ADDR_LOLIM_LO, 8'hff);
    wr(ADDR_LOLIM_HI, 8'hff);
    for (int i = 0; i < 2 * WM && flt_oe !== 1'b0; i++) wt(1);
    chk(fault_pin, 1'b1);
    rd(ADDR_STATUS_ONE, d);
    chk(d[STAT1_FANS_BIT], 1'b1);
    wt(WM);
    rd(ADDR_STATUS_ONE, d);
    chk(d[STAT1_FANS_BIT], 1'b0);
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge i_sys_clk);
    i_reset = 1'b0;
    t_reset();
    t_enable();
    t_mode0();
    t_over();
    t_nospin();
    t_fail();
    finish_test();
  end
  initial begin
    repeat (110000) @(posedge i_sys_clk);
    n_fail++;
    finish_test();
  end
endmodule
